// file: verilog/ssv_supervisor.sv
/*
  Supply and reset supervisor: start-up sequencing, brownout and supply
  monitor handling, reset cause, reset pin shaping, slow clock selection,
  low power modes, AXI4-Lite registers and a masked interrupt.
  Assumes aresetn comes from the zero-power power-on cell and every monitor,
  pin and watchdog input is asynchronous to aclk.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module ssv_supervisor (
  // clock and own power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire ssv_pkg::ssv_axi_req_s axi_req,
  output ssv_pkg::ssv_axi_rsp_s axi_rsp,
  // monitors and external events
  input wire logic backup_supply_ok,
  input wire logic core_supply_low,
  input wire logic usb_phy_supply_low,
  input wire logic watchdog_reset,
  input wire logic xtal_ready,
  input wire logic [15:0] wake_in,
  // external reset pin, open drain
  input wire logic external_reset_pin_in,
  // resets, regulator, analog controls
  output ssv_pkg::ssv_rst_s rst_out,
  output ssv_pkg::ssv_ana_s ana_out,
  // interrupt
  output logic irq
);
  import ssv_pkg::*;

  typedef struct packed {
    ssv_state_e state;
    logic [11:0] cnt;
    logic pin_drive;
    ssv_cause_e cause;
    logic bod_en;
    logic mon_en;
    logic [3:0] mon_thr;
    logic [3:0] mon_rate;
    logic [12:0] mon_cnt;
    logic mon_low;
    logic xtal_en;
    logic sclk_sel;
    logic sclk_is_xtal;
    logic [15:0] wake_mask;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssv_st_s;

  function automatic ssv_st_s reset_state();
    ssv_st_s s;
    s = '0;
    s.state = ST_OFF;
    s.cause = CAUSE_GENERAL;
    s.bod_en = BOD_EN_RST; // R2
    s.mon_en = MON_EN_RST; // R5
    s.mon_thr = THR_RST;
    s.mon_rate = RATE_RST;
    s.wake_mask = WAKE_MASK_RST;
    s.irq_mask = IRQ_MASK_RST;
    return s;
  endfunction : reset_state

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  ssv_st_s st_r;
  ssv_st_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [21:0] raw_in;
  logic [21:0] sync_q;
  logic backup_ok_s;
  logic bod_low_s;
  logic mon_low_s;
  logic wdog_s;
  logic xtal_ready_s;
  logic pin_s;
  logic [15:0] wake_s;

  assign raw_in = {backup_supply_ok, core_supply_low, usb_phy_supply_low, watchdog_reset,
                   xtal_ready, external_reset_pin_in, wake_in};

  // pin idles high and backup reads good so release is not mistaken for an event
  ssv_sync #(.W(22), .RESET_VAL(22'h210000)) u_sync ( // R19
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw_in),
    .q(sync_q)
  );

  assign {backup_ok_s, bod_low_s, mon_low_s, wdog_s, xtal_ready_s, pin_s, wake_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes straight from state
  logic aw_take;
  logic w_take;
  logic ar_take;

  assign axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
  assign axi_rsp.wready = !st_r.w_got && !st_r.bvalid;
  assign axi_rsp.arready = !st_r.rvalid;
  assign axi_rsp.bvalid = st_r.bvalid;
  assign axi_rsp.bresp = st_r.bresp;
  assign axi_rsp.rvalid = st_r.rvalid;
  assign axi_rsp.rdata = st_r.rdata;
  assign axi_rsp.rresp = st_r.rresp;
  assign aw_take = axi_req.awvalid && axi_rsp.awready;
  assign w_take = axi_req.wvalid && axi_rsp.wready;
  assign ar_take = axi_req.arvalid && axi_rsp.arready;

  logic [31:0] mode_img;
  logic [31:0] status_img;

  always_comb
  begin
    mode_img = '0;
    mode_img[SM_BOD_EN_BIT] = st_r.bod_en;
    mode_img[SM_MON_EN_BIT] = st_r.mon_en;
    mode_img[SM_THR_LSB +: 4] = st_r.mon_thr;
    mode_img[SM_RATE_LSB +: 4] = st_r.mon_rate;
    mode_img[SM_XTAL_EN_BIT] = st_r.xtal_en;
    mode_img[SM_SCLK_SEL_BIT] = st_r.sclk_sel;
    status_img = '0;
    status_img[RS_CAUSE_LSB +: 3] = st_r.cause; // R8 R18
    status_img[RS_PIN_BIT] = pin_s;
    status_img[RS_MON_LOW_BIT] = st_r.mon_low;
    status_img[RS_SCLK_XTAL_BIT] = st_r.sclk_is_xtal;
    status_img[RS_REG_ON_BIT] = rst_out.regulator_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic [3:0] ev;
  logic sw_core_rst;
  logic sw_wait;
  logic sw_backup;
  logic [31:0] wimg;
  logic [7:0] waddr;
  logic [3:0] wbe;
  logic [31:0] wd;
  logic [12:0] mon_last;
  logic mon_sample;
  logic core_fault;

  always_comb
  begin
    st_nxt = st_r;
    ev = '0;
    sw_core_rst = 1'b0;
    sw_wait = 1'b0;
    sw_backup = 1'b0;
    wimg = '0;
    waddr = st_r.awaddr;
    wbe = st_r.wstrb;
    wd = st_r.wdata;
    mon_last = '0;
    mon_sample = 1'b0;
    core_fault = st_r.bod_en && bod_low_s; // R3

    // write channel: address and data in either order
    if (aw_take)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
      waddr = axi_req.awaddr;
    end
    if (w_take)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_req.wdata;
      st_nxt.wstrb = axi_req.wstrb;
      wd = axi_req.wdata;
      wbe = axi_req.wstrb;
    end
    if (st_nxt.aw_got && st_nxt.w_got)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (waddr == OFF_SUPPLY_MODE)
      begin
        wimg = merge(mode_img, wd, wbe);
        st_nxt.bod_en = wimg[SM_BOD_EN_BIT]; // R2 R4
        st_nxt.mon_en = wimg[SM_MON_EN_BIT]; // R5
        st_nxt.mon_thr = wimg[SM_THR_LSB +: 4]; // R6
        st_nxt.mon_rate = wimg[SM_RATE_LSB +: 4]; // R7
        st_nxt.xtal_en = wimg[SM_XTAL_EN_BIT]; // R13
        st_nxt.sclk_sel = wimg[SM_SCLK_SEL_BIT]; // R13
      end
      else if (waddr == OFF_RESET_CTRL)
      begin
        sw_core_rst = wbe[0] && wd[RC_CORE_RST_BIT];
        sw_wait = wbe[0] && wd[RC_WAIT_BIT];
        sw_backup = wbe[0] && wd[RC_BACKUP_BIT];
      end
      else if (waddr == OFF_IRQ_MASK)
      begin
        wimg = merge({28'h0000000, st_r.irq_mask}, wd, wbe);
        st_nxt.irq_mask = wimg[3:0];
      end
      else if (waddr == OFF_WAKE_MASK)
      begin
        wimg = merge({16'h0000, st_r.wake_mask}, wd, wbe);
        st_nxt.wake_mask = wimg[15:0];
      end
      else if (waddr == OFF_RESET_STATUS || waddr == OFF_IRQ_STATUS)
      begin
        st_nxt.bresp = RESP_OKAY;
      end
      else
      begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (st_r.bvalid && axi_req.bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    if (st_r.rvalid && axi_req.rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      if (axi_req.araddr == OFF_SUPPLY_MODE)
      begin
        st_nxt.rdata = mode_img;
      end
      else if (axi_req.araddr == OFF_RESET_CTRL)
      begin
        st_nxt.rdata = '0;
      end
      else if (axi_req.araddr == OFF_RESET_STATUS)
      begin
        st_nxt.rdata = status_img;
      end
      else if (axi_req.araddr == OFF_IRQ_STATUS)
      begin
        st_nxt.rdata = {28'h0000000, st_r.irq_stat};
        st_nxt.irq_stat = '0;
      end
      else if (axi_req.araddr == OFF_IRQ_MASK)
      begin
        st_nxt.rdata = {28'h0000000, st_r.irq_mask};
      end
      else if (axi_req.araddr == OFF_WAKE_MASK)
      begin
        st_nxt.rdata = {16'h0000, st_r.wake_mask};
      end
      else
      begin
        st_nxt.rdata = '0;
        st_nxt.rresp = RESP_SLVERR;
      end
    end

    // usb phy supply monitor, powered for MON_WIN of every MON_WIN << rate cycles, rate capped at MON_RATE_MAX
    if (st_r.mon_rate > MON_RATE_MAX)
    begin
      mon_last = (MON_WIN << MON_RATE_MAX) - 13'h0001;
    end
    else
    begin
      mon_last = (MON_WIN << st_r.mon_rate) - 13'h0001;
    end
    if (!st_r.mon_en)
    begin
      st_nxt.mon_cnt = '0;
      st_nxt.mon_low = 1'b0; // R5
    end
    else
    begin
      st_nxt.mon_cnt = (st_r.mon_cnt >= mon_last) ? 13'h0000 : st_r.mon_cnt + 13'h0001;
      // last powered cycle: synchroniser has had the whole window to settle
      mon_sample = (st_r.mon_rate == 4'h0) || (st_r.mon_cnt == MON_WIN - 13'h0001); // R7
      if (mon_sample)
      begin
        st_nxt.mon_low = mon_low_s;
        ev[IRQ_MON_LOW] = mon_low_s && !st_r.mon_low;
      end
    end

    // slow clock: switch only once the crystal is running
    if (st_r.sclk_sel && st_r.xtal_en && xtal_ready_s)
    begin
      st_nxt.sclk_is_xtal = 1'b1; // R13
    end
    else if (!st_r.sclk_sel)
    begin
      st_nxt.sclk_is_xtal = 1'b0;
    end

    // power and reset sequencer
    case (st_r.state)
      ST_OFF:
      begin
        st_nxt.state = ST_REG_WAIT; // R15
        st_nxt.cnt = REG_SETTLE_CYC - 12'h001;
      end
      ST_REG_WAIT:
      begin
        if (st_r.cnt == 12'h000)
        begin
          st_nxt.state = ST_CORE_RST; // R15
          st_nxt.cnt = EXT_PULSE_CYC - 12'h001;
          st_nxt.pin_drive = 1'b1;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - 12'h001;
        end
      end
      ST_CORE_RST:
      begin
        if (st_r.pin_drive)
        begin
          if (st_r.cnt == 12'h000)
          begin
            st_nxt.pin_drive = 1'b0; // R10
            st_nxt.cnt = PIN_BLANK_CYC - 12'h001;
          end
          else
          begin
            st_nxt.cnt = st_r.cnt - 12'h001;
          end
        end
        else if (st_r.cnt != 12'h000)
        begin
          st_nxt.cnt = st_r.cnt - 12'h001;
        end
        // a held button or low core with brownout enabled keeps the core in reset
        else if (pin_s && !core_fault)
        begin
          st_nxt.state = ST_RUN; // R10 R15
        end
      end
      ST_RUN, ST_WAIT_LP:
      begin
        if (core_fault || wdog_s || !pin_s || sw_core_rst)
        begin
          st_nxt.state = ST_CORE_RST; // R9
          st_nxt.cnt = EXT_PULSE_CYC - 12'h001;
          st_nxt.pin_drive = 1'b1;
          if (core_fault)
          begin
            st_nxt.cause = CAUSE_GENERAL; // R3 R8
            ev[IRQ_BROWNOUT] = 1'b1;
          end
          else if (wdog_s)
          begin
            st_nxt.cause = CAUSE_WATCHDOG; // R8
          end
          else if (!pin_s)
          begin
            st_nxt.cause = CAUSE_USER; // R8 R10
            ev[IRQ_USER] = 1'b1;
          end
          else
          begin
            st_nxt.cause = CAUSE_SOFTWARE; // R8
          end
        end
        else if (st_r.state == ST_WAIT_LP && |(wake_s & st_r.wake_mask))
        begin
          st_nxt.state = ST_RUN; // R16
          ev[IRQ_WAKE] = 1'b1;
        end
        else if (st_r.state == ST_RUN && sw_backup)
        begin
          st_nxt.state = ST_BACKUP; // R16
        end
        else if (st_r.state == ST_RUN && sw_wait)
        begin
          st_nxt.state = ST_WAIT_LP; // R16
        end
      end
      ST_BACKUP:
      begin
        if (|(wake_s & st_r.wake_mask))
        begin
          st_nxt.state = ST_REG_WAIT; // R15 R16
          st_nxt.cnt = REG_SETTLE_CYC - 12'h001;
          st_nxt.cause = CAUSE_WAKEUP; // R8
          ev[IRQ_WAKE] = 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = ST_OFF;
      end
    endcase

    // events set after any read clear in the same cycle
    st_nxt.irq_stat = st_nxt.irq_stat | ev;

    if (!backup_ok_s)
    begin
      st_nxt = reset_state(); // R1
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= reset_state(); // R11 R12
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs decoded from state flops
  always_comb
  begin
    rst_out.regulator_en = st_r.state != ST_OFF && st_r.state != ST_BACKUP; // R15 R16
    rst_out.core_reset_n = st_r.state == ST_RUN || st_r.state == ST_WAIT_LP; // R9
    rst_out.periph_reset_n = st_r.state == ST_RUN || st_r.state == ST_WAIT_LP; // R9
    rst_out.core_halt = st_r.state == ST_WAIT_LP;
    rst_out.pin_out = 1'b0;
    rst_out.pin_oe = st_r.pin_drive; // R9 R10
    ana_out.bod_en = st_r.bod_en && rst_out.regulator_en; // R2
    ana_out.mon_power = st_r.mon_en && (st_r.mon_rate == 4'h0 || st_r.mon_cnt < MON_WIN); // R7
    ana_out.mon_threshold = st_r.mon_thr; // R6
    ana_out.rc_osc_en = !st_r.sclk_is_xtal; // R14
    ana_out.xtal_osc_en = st_r.xtal_en || st_r.sclk_is_xtal; // R13 R14
    ana_out.sclk_is_xtal = st_r.sclk_is_xtal;
    ana_out.fast_rc_en = rst_out.regulator_en; // R17
    ana_out.mck_from_fast_rc = 1'b1; // R17
  end

  assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule : ssv_supervisor

// file: verilog/ssv_pkg.sv
/*
  Constants, register map, states and carrier structs of the supply and
  reset supervisor. Assumes a single clock aclk standing in for the always-on
  slow clock domain, and an AXI4-Lite master with 8-bit byte addresses.
*/
// What this block does
// R1: backup supply low resets entire chip
// R2: brownout detector on after reset, software disables
// R3: enabled brownout with low core supply resets core
// R4: software may disable brownout before low power
// R5: usb phy monitor off until software enables
// R6: sixteen selectable monitor thresholds, 1.9V-3.4V
// R7: sampled monitor mode, consumption divided up to 2048
// R8: record last reset cause, five kinds
// R9: generate internal resets, drive reset pin
// R10: shape clean reset pulse, push-button suffices
// R11: slow clock, own reset independent of system
// R12: zero-power power-on reset starts supply controller
// R13: slow clock from RC, software switches crystal
// R14: unused slow oscillator disabled automatically
// R15: regulator enabled first, then core resets released
// R16: low power modes with wide wake-up sources
// R17: master clock from 4 MHz fast RC
// R18: reset cause held until next reset
// R19: monitors and reset pin synchronised first
package ssv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SUPPLY_MODE = 8'h00;
  localparam logic [7:0] OFF_RESET_CTRL = 8'h04;
  localparam logic [7:0] OFF_RESET_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_WAKE_MASK = 8'h14;

  localparam int SM_BOD_EN_BIT = 0;
  localparam int SM_MON_EN_BIT = 1;
  localparam int SM_THR_LSB = 4;
  localparam int SM_RATE_LSB = 8;
  localparam int SM_XTAL_EN_BIT = 12;
  localparam int SM_SCLK_SEL_BIT = 13;
  localparam int RC_CORE_RST_BIT = 0;
  localparam int RC_WAIT_BIT = 4;
  localparam int RC_BACKUP_BIT = 5;
  localparam int RS_CAUSE_LSB = 0;
  localparam int RS_PIN_BIT = 8;
  localparam int RS_MON_LOW_BIT = 9;
  localparam int RS_SCLK_XTAL_BIT = 10;
  localparam int RS_REG_ON_BIT = 11;
  localparam int IRQ_W = 4;
  localparam int IRQ_MON_LOW = 0;
  localparam int IRQ_BROWNOUT = 1;
  localparam int IRQ_USER = 2;
  localparam int IRQ_WAKE = 3;
  localparam int WAKE_W = 16;

  localparam logic BOD_EN_RST = 1'b1;
  localparam logic MON_EN_RST = 1'b0;
  localparam logic [3:0] THR_RST = 4'h0;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [15:0] WAKE_MASK_RST = 16'h0000;
  localparam logic [3:0] MON_RATE_MAX = 4'hb;
  localparam logic [12:0] MON_WIN = 13'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_MHZ = 50;
  localparam int REG_SETTLE_NS = 50000;
  localparam int EXT_PULSE_NS = 60000;
  localparam logic [11:0] REG_SETTLE_CYC = 12'((REG_SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] EXT_PULSE_CYC = 12'((EXT_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] PIN_BLANK_CYC = 12'h004;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_REG_WAIT = 3'h1,
    ST_CORE_RST = 3'h2,
    ST_RUN = 3'h3,
    ST_WAIT_LP = 3'h4,
    ST_BACKUP = 3'h5
  } ssv_state_e;

  typedef enum logic [2:0] {
    CAUSE_GENERAL = 3'h0,
    CAUSE_WAKEUP = 3'h1,
    CAUSE_WATCHDOG = 3'h2,
    CAUSE_SOFTWARE = 3'h3,
    CAUSE_USER = 3'h4
  } ssv_cause_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ssv_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssv_axi_rsp_s;

  typedef struct packed {
    logic regulator_en;
    logic core_reset_n;
    logic periph_reset_n;
    logic core_halt;
    logic pin_out;
    logic pin_oe;
  } ssv_rst_s;

  typedef struct packed {
    logic bod_en;
    logic mon_power;
    logic [3:0] mon_threshold;
    logic rc_osc_en;
    logic xtal_osc_en;
    logic sclk_is_xtal;
    logic fast_rc_en;
    logic mck_from_fast_rc;
  } ssv_ana_s;

endpackage : ssv_pkg

// file: verilog/ssv_sync.sv
/*
  Two-flop level synchroniser, any width.
  Assumes inputs change slowly against aclk; multi-bit inputs are unrelated.
*/
`timescale 1ns/1ns
module ssv_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssv_sync_st_s;

  ssv_sync_st_s st_r;
  ssv_sync_st_s st_nxt;

  always_comb
  begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= {RESET_VAL, RESET_VAL};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;

endmodule : ssv_sync

// file: tb/ssv_supervisor_chk.sv
/*
  Port checker for ssv_supervisor, bound to the design.
  Assumes one clock aclk and the synchronous active-low reset aresetn.
*/
`timescale 1ns/1ns
module ssv_supervisor_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire ssv_pkg::ssv_axi_req_s axi_req,
  input wire ssv_pkg::ssv_axi_rsp_s axi_rsp,
  // monitors
  input wire logic backup_supply_ok,
  input wire logic core_supply_low,
  // resets and analog controls
  input wire ssv_pkg::ssv_rst_s rst_out,
  input wire ssv_pkg::ssv_ana_s ana_out
);
  import ssv_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // length of the current pin drive
  logic [12:0] pcnt_r;
  logic [12:0] pcnt_nxt;
  always_comb pcnt_nxt = rst_out.pin_oe ? pcnt_r + 13'h1 : 13'h0;
  always_ff @(posedge aclk) pcnt_r <= aresetn ? pcnt_nxt : 13'h0;
  ////////////////////////////////////////////////////////////////////////////
  property p_start;
    $rose(aresetn) |-> !rst_out.regulator_en && !ana_out.mon_power ##[1:3] ana_out.bod_en;
  endproperty
  a_start: assert property (p_start) else $error("start-up outputs wrong");
  property p_reg_first;
    !rst_out.regulator_en |-> !rst_out.core_reset_n && !rst_out.periph_reset_n;
  endproperty
  a_reg_first: assert property (p_reg_first) else $error("core out of reset unpowered");
  property p_osc;
    ana_out.rc_osc_en != ana_out.sclk_is_xtal && (ana_out.xtal_osc_en || !ana_out.sclk_is_xtal);
  endproperty
  a_osc: assert property (p_osc) else $error("slow oscillator enables wrong");
  property p_mck;
    rst_out.regulator_en |-> ana_out.fast_rc_en && ana_out.mck_from_fast_rc;
  endproperty
  a_mck: assert property (p_mck) else $error("master clock not on fast rc");
  property p_pulse;
    $fell(rst_out.pin_oe) |-> pcnt_r == 13'(EXT_PULSE_CYC);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pin pulse length wrong");
  property p_pin;
    rst_out.pin_oe |-> !rst_out.pin_out && !rst_out.core_reset_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven outside reset");
  property p_bod;
    (ana_out.bod_en && core_supply_low) [*3] |-> ##[0:3] !rst_out.core_reset_n;
  endproperty
  a_bod: assert property (p_bod) else $error("brownout gave no core reset");
  property p_backup;
    !backup_supply_ok [*3] |-> ##[0:2] !rst_out.regulator_en;
  endproperty
  a_backup: assert property (p_backup) else $error("backup loss gave no reset");
  property p_bhold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_bnext;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> axi_rsp.bvalid;
  endproperty
  a_bnext: assert property (p_bnext) else $error("write response late");
endmodule : ssv_supervisor_chk

bind ssv_supervisor ssv_supervisor_chk i_ssv_supervisor_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .backup_supply_ok(backup_supply_ok),
  .core_supply_low(core_supply_low), .rst_out(rst_out), .ana_out(ana_out));

// file: tb/ssv_pin_partner.sv
/*
  Reset pin partner: pull-up, push-button and a device timing low pulses.
  Assumes the supervisor only ever pulls the pin low.
*/
`timescale 1ns/1ns
module ssv_pin_partner (
  // clock
  input wire logic aclk,
  // pin drivers
  input wire logic pin_oe,
  input wire logic press,
  // wire level and last low span
  output logic pin_level,
  output int low_len
);
  int cnt = 0;
  // open drain with pull-up: released pin reads high
  assign pin_level = !(pin_oe || press);
  always_ff @(posedge aclk)
  begin
    cnt <= pin_level ? 0 : cnt + 1;
    if (pin_level && cnt != 0) low_len <= cnt;
  end
endmodule : ssv_pin_partner

// file: tb/tb.sv
/*
  Self-checking bench of ssv_supervisor with a reset pin partner.
  Assumes 50 MHz aclk and the designer's register map and timing.
*/
`timescale 1ns/1ns
module tb;
  import ssv_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  ssv_axi_req_s q = '0;
  ssv_axi_rsp_s rsp;
  logic bok = 1, csl = 0, usl = 0, wdg = 0, xrdy = 0, press = 0, irq, pin;
  logic [15:0] wake = '0;
  ssv_rst_s ro;
  ssv_ana_s ao;
  int low_len, err_count = 0, checks = 0, n, i, k;
  int seed = 32'hf355150b;
  logic [31:0] rd, d;
  logic [7:0] a;
  logic [3:0] s;
  logic [1:0] rs;
  logic [31:0] mdl [logic [7:0]];
  logic [2:0] cz [4] = '{CAUSE_SOFTWARE, CAUSE_WATCHDOG, CAUSE_USER, CAUSE_GENERAL};
  always #10 aclk = ~aclk;
  ssv_supervisor i_ssv_supervisor (.aclk(aclk), .aresetn(aresetn), .axi_req(q), .axi_rsp(rsp),
    .backup_supply_ok(bok), .core_supply_low(csl), .usb_phy_supply_low(usl),
    .watchdog_reset(wdg), .xtal_ready(xrdy), .wake_in(wake), .external_reset_pin_in(pin),
    .rst_out(ro), .ana_out(ao), .irq(irq));
  ssv_pin_partner i_ssv_pin_partner (.aclk(aclk), .pin_oe(ro.pin_oe), .press(press),
    .pin_level(pin), .low_len(low_len));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // callers enter just after a rising edge; readies sampled on the low phase
  task wr(input logic [7:0] wa, input logic [31:0] wd, input logic [3:0] ws);
    logic aw, w, b;
    q <= '{awvalid:1, awaddr:wa, wvalid:1, wdata:wd, wstrb:ws, bready:1, default:0};
    do
    begin
      @(negedge aclk);
      aw = q.awvalid && rsp.awready;
      w = q.wvalid && rsp.wready;
      b = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge aclk);
      if (aw) q.awvalid <= 0;
      if (w) q.wvalid <= 0;
    end
    while (!b);
  endtask : wr
  task rdr(input logic [7:0] ra);
    logic ar, r;
    q <= '{arvalid:1, araddr:ra, rready:1, default:0};
    do
    begin
      @(negedge aclk);
      ar = q.arvalid && rsp.arready;
      r = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge aclk);
      if (ar) q.arvalid <= 0;
    end
    while (!r);
  endtask : rdr
  task wcore(input logic v);
    do @(negedge aclk);
    while (ro.core_reset_n !== v);
    @(posedge aclk);
  endtask : wcore
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (ro.core_reset_n !== 1);
    @(posedge aclk);
    k = REG_SETTLE_CYC + EXT_PULSE_CYC;
    chk("startup", 32'(n >= k && n <= k + 16), 1);
    chk("pulse", low_len, EXT_PULSE_CYC);
    rdr(OFF_SUPPLY_MODE);
    chk("mode", rd, 32'h1);
    rdr(OFF_RESET_STATUS);
    chk("status", rd, 32'h900);
    rdr(8'h18);
    chk("unm_rd", rd, 0);
    chk("unm_rresp", rs, RESP_SLVERR);
    wr(8'h18, 32'hffffffff, 4'hf);
    chk("unm_bresp", rs, RESP_SLVERR);
    mdl[OFF_IRQ_MASK] = 32'(IRQ_MASK_RST);
    mdl[OFF_WAKE_MASK] = 32'(WAKE_MASK_RST);
    repeat (12)
    begin
      a = ($random(seed) & 1) ? OFF_IRQ_MASK : OFF_WAKE_MASK;
      d = $random(seed);
      s = $random(seed);
      wr(a, d, s);
      for (i = 0; i < 4; i++) if (s[i]) mdl[a][8*i+:8] = d[8*i+:8];
      mdl[a] &= (a == OFF_IRQ_MASK) ? 32'hf : 32'hffff;
      rdr(a);
      chk("mask_reg", rd, mdl[a]);
    end
    for (i = 0; i < 16; i++)
    begin
      wr(OFF_SUPPLY_MODE, 32'h1 | (i << SM_THR_LSB), 4'hf);
      @(negedge aclk);
      chk("thr", ao.mon_threshold, i);
      @(posedge aclk);
    end
    for (k = 0; k < 2; k++)
    begin
      wr(OFF_SUPPLY_MODE, 32'h3 | (k << SM_RATE_LSB), 4'hf);
      usl <= k[0];
      repeat (16) @(posedge aclk);
      n = 0;
      repeat (64)
      begin
        @(negedge aclk);
        n += ao.mon_power;
      end
      chk("sampled", n, k ? 32 : 64);
      @(posedge aclk);
      rdr(OFF_IRQ_STATUS);
      chk("mon_stat", rd, k);
    end
    xrdy <= 1;
    wr(OFF_SUPPLY_MODE, 32'h3001, 4'hf);
    repeat (8) @(negedge aclk);
    chk("xtal", ao.sclk_is_xtal, 1);
    chk("rc_off", ao.rc_osc_en, 0);
    @(posedge aclk);
    wr(OFF_IRQ_MASK, 32'h4, 4'hf);
    for (k = 0; k < 4; k++)
    begin
      case (k)
        0: wr(OFF_RESET_CTRL, 32'h1, 4'h1);
        1: wdg <= 1;
        2: press <= 1;
        default: csl <= 1;
      endcase
      wcore(0);
      {wdg, press, csl} <= 3'b0;
      wcore(1);
      rdr(OFF_RESET_STATUS);
      chk("cause", rd[2:0], cz[k]);
      chk("irq", irq, k == 2);
      rdr(OFF_IRQ_STATUS);
      chk("irq_stat", rd, k == 2 ? 4 : k == 3 ? 2 : 0);
      chk("irq_clr", irq, 0);
      if (k != 2) chk("pulse", low_len, EXT_PULSE_CYC);
    end
    // brownout switched off before low power
    wr(OFF_SUPPLY_MODE, 32'h3000, 4'hf);
    csl <= 1;
    repeat (20) @(negedge aclk);
    chk("bod_off", {ao.bod_en, ro.core_reset_n}, 2'b01);
    @(posedge aclk);
    csl <= 0;
    wr(OFF_WAKE_MASK, 32'h8, 4'hf);
    wr(OFF_IRQ_MASK, 32'h8, 4'hf);
    wr(OFF_RESET_CTRL, 32'h10, 4'h1);
    @(negedge aclk);
    chk("halt", ro.core_halt, 1);
    @(posedge aclk);
    wake <= 16'h8;
    repeat (8) @(negedge aclk);
    chk("woken", {ro.core_halt, ro.core_reset_n, irq}, 3'b011);
    @(posedge aclk);
    wake <= 0;
    rdr(OFF_IRQ_STATUS);
    chk("wake_stat", rd, 32'h8);
    rdr(OFF_RESET_STATUS);
    chk("cause_kept", rd[2:0], CAUSE_GENERAL);
    wr(OFF_RESET_CTRL, 32'h20, 4'h1);
    repeat (4) @(negedge aclk);
    chk("reg_off", ro.regulator_en, 0);
    @(posedge aclk);
    wake <= 16'h8;
    do @(negedge aclk);
    while (ro.regulator_en !== 1);
    @(posedge aclk);
    wake <= 0;
    wcore(1);
    rdr(OFF_RESET_STATUS);
    chk("cause_wake", rd[2:0], CAUSE_WAKEUP);
    bok <= 0;
    repeat (5) @(negedge aclk);
    chk("bu_reset", {ro.regulator_en, ro.core_reset_n}, 2'b00);
    @(posedge aclk);
    bok <= 1;
    wcore(1);
    rdr(OFF_SUPPLY_MODE);
    chk("bu_mode", rd, 32'h1);
    tally_and_finish();
  end
endmodule : tb
